/* core/mrc_device.sv */
// device end: hardware and software reset control of a seven-channel mapper
// Summary of operation
// - host hardware-resets after every power-up
// - hardware reset clears registers 04h to 03fh
// - host holds reset low fifteen clocks
// - global soft reset issued after 10 ms
// - writing 91h to 005h enters soft reset
// - any other value leaves soft reset
// - soft reset clears state machines only
// - reset byte reads 01h or 00h
// - channel reset bit pulse resets that channel
// - host resets channel after mode change
// - cleared activity bit powers channel down
// - host masks unused channel interrupts with ffh
`timescale 1ns/1ps
`default_nettype none
module mrc_device #(
  parameter int NUM_CH = mrc_pkg::NUM_CH
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  mrc_if.device                  bus,
  output logic                   hw_reset_out,
  output logic                   global_soft_reset,
  output logic [NUM_CH-1:0]      ch_soft_reset,
  output logic [NUM_CH-1:0]      ch_power_down,
  output logic [NUM_CH-1:0]      ch_irq_masked
);
  // ****************************************
  // reset pin qualification
  // ****************************************
  logic       sync1_reg;
  logic       sync2_reg;
  logic [4:0] low_cnt_reg;
  logic       int_rst_reg;
  wire        cnt_done = (low_cnt_reg == mrc_pkg::HW_RST_CYCLES);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // start as if the pin were low: reset holds until the pin is seen high
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      low_cnt_reg <= 5'd0;
      int_rst_reg <= 1'b1;
    end else begin
      sync1_reg <= bus.hw_reset_n_in;
      sync2_reg <= sync1_reg;
      if (sync2_reg) begin
        low_cnt_reg <= 5'd0;
        int_rst_reg <= 1'b0;
      end else if (!cnt_done) begin
        low_cnt_reg <= low_cnt_reg + 5'd1;
      end else begin
        int_rst_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // register decode
  // ****************************************
  // true when an address falls in a channel window that exists
  function automatic logic chan_hit(input logic [8:0] a);
    chan_hit = (a[8:6] != 3'd0) && (a[8:6] <= 3'(NUM_CH));
  endfunction

  // true when a mask byte has every bit set
  function automatic logic all_masked(input logic [7:0] b);
    all_masked = (b == mrc_pkg::MASK_ALL);
  endfunction

  wire [2:0] ch_sel  = bus.addr[8:6];
  wire [5:0] ch_off  = bus.addr[5:0];
  wire       is_ch   = chan_hit(bus.addr);
  wire [2:0] ch_idx  = ch_sel - 3'd1;
  wire       is_glob = (ch_sel == 3'd0) && (bus.addr >= mrc_pkg::GLOBAL_LO);
  wire       wr_en   = bus.cs && bus.wr;
  wire       rd_en   = bus.cs && bus.rd;

  logic [7:0] glob_reg [mrc_pkg::GLOBAL_LO:mrc_pkg::GLOBAL_HI];
  logic [7:0] chan_reg [NUM_CH][64];
  logic       soft_reg;
  logic [7:0] rdata_reg;
  logic       rvalid_reg;

  wire [7:0] ch_rd = is_ch ? chan_reg[ch_idx][ch_off] : 8'h00;
  wire [7:0] gl_rd = (bus.addr == mrc_pkg::SOFT_RST_ADDR)
                     ? (soft_reg ? mrc_pkg::SOFT_RST_ON_RD : mrc_pkg::SOFT_RST_OFF_RD)
                     : (is_glob ? glob_reg[bus.addr] : 8'h00);
  wire [7:0] rd_val = is_ch ? ch_rd : gl_rd;

  // ****************************************
  // soft reset byte, cleared by hardware reset or by writing any non-key value
  // ****************************************
  // the key byte itself is not kept; a read answers with the state
  wire key_wr  = wr_en && (bus.addr == mrc_pkg::SOFT_RST_ADDR);
  wire glob_wr = wr_en && is_glob && (bus.addr != mrc_pkg::SOFT_RST_ADDR);
  wire chan_wr = wr_en && is_ch;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      soft_reg <= 1'b0;
    end else if (int_rst_reg) begin
      soft_reg <= 1'b0;
    end else if (key_wr) begin
      soft_reg <= (bus.wdata == mrc_pkg::SOFT_RST_KEY);
    end
  end

  // ****************************************
  // global registers 04h to 03fh
  // ****************************************
  // writes during hardware reset are dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int a = 4; a <= 63; a++) glob_reg[a] <= mrc_pkg::REG_RESET_VAL;
    end else if (int_rst_reg) begin
      for (int a = 4; a <= 63; a++) glob_reg[a] <= mrc_pkg::REG_RESET_VAL;
    end else if (glob_wr) begin
      glob_reg[bus.addr] <= bus.wdata;
    end
  end

  // ****************************************
  // channel registers, untouched by soft reset
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++)
        for (int o = 0; o < 64; o++) chan_reg[c][o] <= mrc_pkg::REG_RESET_VAL;
    end else if (int_rst_reg) begin
      for (int c = 0; c < NUM_CH; c++)
        for (int o = 0; o < 64; o++) chan_reg[c][o] <= mrc_pkg::REG_RESET_VAL;
    end else if (chan_wr) begin
      chan_reg[ch_idx][ch_off] <= bus.wdata;
    end
  end

  // ****************************************
  // read answer, one cycle after the strobe
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rd_en;
    end
  end

  // data is zero outside the answer cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_en ? rd_val : 8'h00;
    end
  end
  assign bus.rdata  = rdata_reg;
  assign bus.rvalid = rvalid_reg;

  // ****************************************
  // per channel output decode
  // ****************************************
  logic [NUM_CH-1:0] ch_rst_next;
  logic [NUM_CH-1:0] ch_pd_next;
  logic [NUM_CH-1:0] ch_msk_next;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    assign ch_rst_next[g] = int_rst_reg || soft_reg
                            || chan_reg[g][mrc_pkg::CH_CTRL_OFF][mrc_pkg::CH_RST_BIT];
    assign ch_pd_next[g]  = !chan_reg[g][mrc_pkg::CH_MODE_OFF][mrc_pkg::ACTIVE_BIT];
    assign ch_msk_next[g] = all_masked(chan_reg[g][mrc_pkg::CH_MASK0_OFF])
                            && all_masked(chan_reg[g][mrc_pkg::CH_MASK0_OFF + 6'h01])
                            && all_masked(chan_reg[g][mrc_pkg::CH_MASK2_OFF]);
  end

  // ****************************************
  // reset and power outputs
  // ****************************************
  logic [NUM_CH-1:0] ch_rst_reg;
  logic [NUM_CH-1:0] ch_pd_reg;
  logic [NUM_CH-1:0] ch_msk_reg;
  logic              hw_out_reg;
  logic              gsr_reg;

  // all channels held in reset and powered down until released
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ch_rst_reg <= '1;
      ch_pd_reg  <= '1;
      ch_msk_reg <= '0;
      hw_out_reg <= 1'b1;
      gsr_reg    <= 1'b0;
    end else begin
      hw_out_reg <= int_rst_reg;
      gsr_reg    <= soft_reg;
      ch_rst_reg <= ch_rst_next;
      ch_pd_reg  <= ch_pd_next;
      ch_msk_reg <= ch_msk_next;
    end
  end

  assign hw_reset_out      = hw_out_reg;
  assign global_soft_reset = gsr_reg;
  assign ch_soft_reset     = ch_rst_reg;
  assign ch_power_down     = ch_pd_reg;
  assign ch_irq_masked     = ch_msk_reg;
endmodule
`default_nettype wire

/* core/mrc_host.sv */
// host end: reset pin driver and register writes for the mapper
`timescale 1ns/1ps
`default_nettype none
module mrc_host #(
  parameter int PWRUP_CYCLES = mrc_pkg::POWERUP_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  mrc_if.host             bus,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_wr,
  input  wire logic [8:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic [7:0]      rsp_data,
  output logic            rsp_valid
);
  typedef enum logic [1:0] {MH_HOLD = 2'b00, MH_WAIT = 2'b01, MH_RUN = 2'b11} mh_state_t;
  mh_state_t   state_reg;
  logic [31:0] cnt_reg;
  logic        rstn_reg;
  logic        cs_reg;
  logic        wr_reg;
  logic        rd_reg;
  logic [8:0]  addr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  rsp_reg;
  logic        rspv_reg;
  logic        ready_reg;
  wire         take = ready_reg && cmd_valid;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= MH_HOLD;
      cnt_reg   <= 32'd0;
      rstn_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        MH_HOLD: begin
          cnt_reg <= cnt_reg + 32'd1;
          if (cnt_reg >= 32'(mrc_pkg::HW_RST_CYCLES) + 32'd4) begin
            state_reg <= MH_WAIT;
            rstn_reg  <= 1'b1;
          end
        end
        MH_WAIT: begin
          cnt_reg <= cnt_reg + 32'd1;
          if (cnt_reg >= 32'(PWRUP_CYCLES)) state_reg <= MH_RUN;
        end
        MH_RUN: cnt_reg <= cnt_reg;
        default: state_reg <= MH_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      addr_reg  <= 9'h000;
      wdata_reg <= 8'h00;
      rsp_reg   <= 8'h00;
      rspv_reg  <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_reg == MH_RUN) && !take;
      cs_reg    <= take;
      wr_reg    <= take && cmd_wr;
      rd_reg    <= take && !cmd_wr;
      addr_reg  <= take ? cmd_addr : addr_reg;
      wdata_reg <= take ? cmd_wdata : wdata_reg;
      rspv_reg  <= bus.rvalid;
      rsp_reg   <= bus.rvalid ? bus.rdata : rsp_reg;
    end
  end

  assign cmd_ready         = ready_reg;
  assign bus.hw_reset_n_in = rstn_reg;
  assign bus.cs            = cs_reg;
  assign bus.wr            = wr_reg;
  assign bus.rd            = rd_reg;
  assign bus.addr          = addr_reg;
  assign bus.wdata         = wdata_reg;
  assign rsp_data          = rsp_reg;
  assign rsp_valid         = rspv_reg;
endmodule
`default_nettype wire

/* core/mrc_if.sv */
// interface joining the host and the mapper reset control
`timescale 1ns/1ps
`default_nettype none
interface mrc_if;
  logic       hw_reset_n_in;
  logic       cs;
  logic       wr;
  logic       rd;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  modport device (input hw_reset_n_in, cs, wr, rd, addr, wdata, output rdata, rvalid);
  modport host   (output hw_reset_n_in, cs, wr, rd, addr, wdata, input rdata, rvalid);
endinterface
`default_nettype wire

/* core/mrc_pkg.sv */
// package of constants for the mapper reset control block
package mrc_pkg;
  localparam int          NUM_CH          = 7;
  localparam int          ADDR_W          = 9;
  localparam logic [8:0]  GLOBAL_LO       = 9'h004;
  localparam logic [8:0]  GLOBAL_HI       = 9'h03f;
  localparam logic [8:0]  SOFT_RST_ADDR   = 9'h005;
  localparam logic [7:0]  SOFT_RST_KEY    = 8'h91;
  localparam logic [7:0]  SOFT_RST_ON_RD  = 8'h01;
  localparam logic [7:0]  SOFT_RST_OFF_RD = 8'h00;
  localparam logic [5:0]  CH_MODE_OFF     = 6'h00;
  localparam logic [5:0]  CH_ALARM_OFF    = 6'h01;
  localparam logic [5:0]  CH_RDI_OFF      = 6'h02;
  localparam logic [5:0]  CH_MASK0_OFF    = 6'h09;
  localparam logic [5:0]  CH_MASK2_OFF    = 6'h0b;
  localparam logic [5:0]  CH_CTRL_OFF     = 6'h0c;
  localparam int          ACTIVE_BIT      = 7;
  localparam int          CH_RST_BIT      = 5;
  localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
  localparam logic [7:0]  MASK_ALL        = 8'hff;
  localparam logic [4:0]  HW_RST_CYCLES   = 5'd10;
  localparam int          CLK_MHZ         = 200;
  localparam int          POWERUP_MS      = 10;
  localparam int          POWERUP_CYCLES  = POWERUP_MS * 1000 * CLK_MHZ;
endpackage

/* dv/mrc_asserts.sv */
// concurrent checks on the bus joining host and reset control
`timescale 1ns/1ps
`default_nettype none
module mrc_asserts (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       hw_reset_n_in,
  input wire logic       cs,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid
);
  logic known_reg;
  logic soft_reg;
  wire  key_wr = cs && wr && addr == mrc_pkg::SOFT_RST_ADDR;
  // expected soft reset state, unknown again after any pin reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      known_reg <= 1'b0;
      soft_reg  <= 1'b0;
    end else if (!hw_reset_n_in) begin
      known_reg <= 1'b0;
    end else if (key_wr) begin
      known_reg <= 1'b1;
      soft_reg  <= wdata == mrc_pkg::SOFT_RST_KEY;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_rd_req;
    cs && rd;
  endsequence
  sequence s_pin_held;
    !hw_reset_n_in [*8] ##1 !hw_reset_n_in ##1 !hw_reset_n_in;
  endsequence
  a_rd_answer: assert property (s_rd_req |=> rvalid)
    else $error("read strobe without answer");
  a_answer_cause: assert property (rvalid |-> $past(cs && rd))
    else $error("answer without read strobe");
  a_reset_byte: assert property (rvalid && $past(addr) == mrc_pkg::SOFT_RST_ADDR |->
    rdata == mrc_pkg::SOFT_RST_ON_RD || rdata == mrc_pkg::SOFT_RST_OFF_RD)
    else $error("reset byte reads other value");
  a_soft_state: assert property (rvalid && $past(addr) == mrc_pkg::SOFT_RST_ADDR
    && known_reg |-> rdata == (soft_reg ? 8'h01 : 8'h00))
    else $error("reset byte disagrees with key");
  a_unmapped_zero: assert property (rvalid && $past(addr) < mrc_pkg::GLOBAL_LO |->
    rdata == 8'h00) else $error("low address reads nonzero");
  a_req_spacing: assert property (cs && (wr || rd) |=> !cs)
    else $error("strobes back to back");
  a_rw_exclusive: assert property (cs |-> !(wr && rd))
    else $error("read and write together");
  a_pin_long: assert property ($fell(hw_reset_n_in) |-> s_pin_held)
    else $error("reset pin low too short");
  a_no_req_hwrst: assert property (!hw_reset_n_in |-> !cs)
    else $error("access during pin reset");
endmodule
`default_nettype wire

/* dv/mrc_tb_top.sv */
// self-checking bench for host and device ends of reset control
`timescale 1ns/1ps
`default_nettype none
module mrc_tb_top;
  typedef struct packed {logic wr; logic [8:0] addr; logic [7:0] data;} mrc_row_t;
  logic       clk_sys = 1'b0;
  logic       rst_dev = 1'b1;
  logic       rst_host = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_wr = 1'b0;
  logic [8:0] cmd_addr = 9'h000;
  logic [7:0] cmd_wdata = 8'h00;
  logic       cmd_ready, rsp_valid, hw_reset_out, global_soft_reset;
  logic [7:0] rsp_data, q;
  logic [6:0] ch_soft_reset, ch_power_down, ch_irq_masked;
  int         failures = 0;
  int         checked = 0;
  // reads hold the expected byte in data
  mrc_row_t   rows [14] = '{'{1'b1, 9'h004, 8'ha5}, '{1'b0, 9'h004, 8'ha5},
    '{1'b0, 9'h000, 8'h00}, '{1'b1, 9'h040, 8'h80}, '{1'b0, 9'h040, 8'h80},
    '{1'b1, 9'h005, 8'h91}, '{1'b0, 9'h005, 8'h01}, '{1'b0, 9'h004, 8'ha5},
    '{1'b1, 9'h005, 8'h92}, '{1'b0, 9'h005, 8'h00}, '{1'b1, 9'h1c9, 8'hff},
    '{1'b1, 9'h1ca, 8'hff}, '{1'b1, 9'h1cb, 8'hff}, '{1'b0, 9'h1cb, 8'hff}};
  always #2.5 clk_sys = ~clk_sys;
  mrc_if bus_if ();
  mrc_host #(.PWRUP_CYCLES(20)) u_mrc_host (.clk_sys(clk_sys), .rst(rst_host), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
  mrc_device u_mrc_device (.clk_sys(clk_sys), .rst(rst_dev), .bus(bus_if),
    .hw_reset_out(hw_reset_out), .global_soft_reset(global_soft_reset),
    .ch_soft_reset(ch_soft_reset), .ch_power_down(ch_power_down),
    .ch_irq_masked(ch_irq_masked));
  mrc_asserts u_mrc_asserts (.clk_sys(clk_sys), .rst(rst_dev),
    .hw_reset_n_in(bus_if.hw_reset_n_in), .cs(bus_if.cs), .wr(bus_if.wr), .rd(bus_if.rd),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one host command; read data lands two cycles after take
  task automatic xfer(input logic w, input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 300) failures++;
    cmd_valid = 1'b1;
    cmd_wr = w;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    q = 8'h00;
    repeat (3) begin
      @(negedge clk_sys);
      if (rsp_valid === 1'b1) q = rsp_data;
    end
  endtask
  initial begin
    #20000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    chk({7'h00, hw_reset_out}, 8'h01);
    rst_dev = 1'b0;
    rst_host = 1'b0;
    xfer(1'b0, 9'h004, 8'h00);
    chk(q, 8'h00);
    chk({7'h00, hw_reset_out}, 8'h00);
    chk({1'b0, ch_power_down}, 8'h7f);
    foreach (rows[i]) begin
      xfer(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) chk(q, rows[i].data);
    end
    chk({1'b0, ch_power_down}, 8'h7e);
    chk({1'b0, ch_irq_masked}, 8'h40);
    xfer(1'b1, 9'h005, 8'h91);
    chk({global_soft_reset, ch_soft_reset}, 8'hff);
    xfer(1'b1, 9'h005, 8'h00);
    chk({global_soft_reset, ch_soft_reset}, 8'h00);
    xfer(1'b1, 9'h0cc, 8'h20);
    chk({global_soft_reset, ch_soft_reset}, 8'h04);
    xfer(1'b1, 9'h0cc, 8'h00);
    chk({global_soft_reset, ch_soft_reset}, 8'h00);
    // host restart pulls the pin low again
    rst_host = 1'b1;
    @(negedge clk_sys);
    rst_host = 1'b0;
    repeat (14) @(negedge clk_sys);
    chk({7'h00, hw_reset_out}, 8'h01);
    xfer(1'b0, 9'h004, 8'h00);
    chk(q, 8'h00);
    xfer(1'b0, 9'h040, 8'h00);
    chk(q, 8'h00);
    chk({1'b0, ch_irq_masked}, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
